// ### adc_conv_ctl.sv
// Conversion sequencer, trigger handling and AXI4-Lite registers of the integrating converter
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module adc_conv_ctl
   import adc_ctl_pkg::*;
#(
   parameter int unsigned P_INT60_CYC = adc_ctl_pkg::INT60_CYC,
   parameter int unsigned P_INT50_CYC = adc_ctl_pkg::INT50_CYC,
   parameter int unsigned P_VERN_CYC = adc_ctl_pkg::VERN_CYC,
   parameter int unsigned P_AZ_CYC = adc_ctl_pkg::AZ_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // AXI4-Lite write channels
   input wire logic [adc_ctl_pkg::AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [adc_ctl_pkg::AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Control pins
   input wire logic external_convert_trigger,
   input wire logic line_frequency_select,
   output logic busy_out_n,
   output logic result_valid_output,
   output logic irq,
   // Integrator front end
   input wire logic [adc_ctl_pkg::READ_W-1:0] deint_count,
   input wire logic [adc_ctl_pkg::READ_W-1:0] vernier_count,
   output logic integrate_en,
   output logic vernier_en,
   output logic autozero_en,
   output logic [7:0] gain_trim
);
   import adc_ctl_pkg::*;

   // Length of one of the ten measurement cycles per line setting
   localparam logic [CNT_W-1:0] MEAS60_LEN = CNT_W'(P_INT60_CYC / MEAS_CYCLES);
   localparam logic [CNT_W-1:0] MEAS50_LEN = CNT_W'(P_INT50_CYC / MEAS_CYCLES);
   localparam logic [CNT_W-1:0] VERN_LEN = CNT_W'(P_VERN_CYC);
   localparam logic [CNT_W-1:0] AZ_LEN = CNT_W'(P_AZ_CYC);
   localparam logic [3:0] LAST_PHASE = 4'(MEAS_CYCLES - 1);
   localparam logic [3:0] SUM_END = 4'(MEAS_CYCLES);

   // Whole controller state
   typedef struct packed {
      state_e state;
      logic [CNT_W-1:0] cnt;       // Phase timer
      logic [3:0] phase;           // Measurement cycle index
      logic [3:0] sidx;            // Summation index
      logic [RES_W-1:0] acc;       // Running sum
      logic [RES_W-1:0] result;    // Output latch
      logic ext;                   // Running conversion came from the pin
      logic mod;                   // Running conversion uses altered values
      logic line;                  // Line setting frozen at start
      logic busy;                  // Status busy bit
      logic avail;                 // New data available
      logic [15:0] offset;         // Altered offset
      logic [7:0] gain;            // Altered gain
      logic [7:0] gain_trim;
      logic [EVT_W-1:0] ist;
      logic [EVT_W-1:0] ien;
      logic irq;
      logic busy_n;
      logic rdy_out;
      logic int_en;
      logic vern_en;
      logic az_en;
      logic trig_s1;
      logic trig_s2;
      logic trig_prev;
      logic line_s1;
      logic line_s2;
      logic awrdy;
      logic wrdy;
      logic aw_have;
      logic w_have;
      logic bvalid;
      logic [1:0] bresp;
      logic [AXI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arrdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } ctl_s;
   ctl_s q;
   ctl_s d;

   // Memory hookup
   logic mem_we;
   logic [READ_W-1:0] mem_rdata;
   logic trig_fall;
   logic [CNT_W-1:0] meas_len;

   reading_mem #(.W(READ_W), .DEPTH(16), .AW(4)) u_mem (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .we(mem_we),
      .waddr(q.phase),
      .wdata(deint_count),
      .raddr(q.sidx),
      .rdata(mem_rdata)
   );

   // Edge taken from the second and third stage only
   assign trig_fall = q.trig_prev & ~q.trig_s2;
   // Period per measurement cycle follows the frozen line setting
   assign meas_len = q.line ? MEAS60_LEN : MEAS50_LEN;
   assign mem_we = (q.state == S_MEAS) && (q.cnt == meas_len - 1'b1);

   // Next-state logic: bus slave, sequencer, interrupts
   always_comb
   begin
      logic cmd_def;
      logic cmd_mod;
      logic rd_result;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] clr;
      cmd_def = 1'b0;
      cmd_mod = 1'b0;
      rd_result = 1'b0;
      evt = '0;
      clr = '0;
      d = q;
      // Pin synchronisers
      d.trig_s1 = external_convert_trigger;
      d.trig_s2 = q.trig_s1;
      d.trig_prev = q.trig_s2;
      d.line_s1 = line_frequency_select;
      d.line_s2 = q.line_s1;
      // Write address and data accepted in either order
      if (awvalid && q.awrdy)
      begin
         d.awrdy = 1'b0;
         d.aw_have = 1'b1;
         d.waddr = awaddr;
      end
      if (wvalid && q.wrdy)
      begin
         d.wrdy = 1'b0;
         d.w_have = 1'b1;
         d.wdata = wdata;
         d.wstrb = wstrb;
      end
      // Perform the write once both halves are held
      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         unique case ({q.waddr[AXI_AW-1:2], 2'b00})
            OFF_CTRL:
            begin
               cmd_def = q.wstrb[0] & q.wdata[CTRL_DEF_BIT];
               cmd_mod = q.wstrb[0] & q.wdata[CTRL_MOD_BIT];
            end
            OFF_OFFSET:
            begin
               if (q.wstrb[0]) d.offset[7:0] = q.wdata[7:0];
               if (q.wstrb[1]) d.offset[15:8] = q.wdata[15:8];
            end
            OFF_GAIN: if (q.wstrb[0]) d.gain = q.wdata[7:0];
            OFF_INT_CLEAR: if (q.wstrb[0]) clr = q.wdata[EVT_W-1:0];
            OFF_INT_ENABLE: if (q.wstrb[0]) d.ien = q.wdata[EVT_W-1:0];
            // Read-only registers ignore writes but answer OKAY
            OFF_STATUS, OFF_RESULT, OFF_INT_STATUS: d.bresp = RESP_OKAY;
            default: d.bresp = RESP_SLVERR;
         endcase
      end
      if (q.bvalid && bready)
      begin
         d.bvalid = 1'b0;
         d.awrdy = 1'b1;
         d.wrdy = 1'b1;
      end
      // Read: data registered, answered the cycle after the address
      if (arvalid && q.arrdy)
      begin
         d.arrdy = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         unique case ({araddr[AXI_AW-1:2], 2'b00})
            OFF_STATUS:
            begin
               d.rdata[ST_BUSY_BIT] = q.busy;
               d.rdata[ST_CONV_BIT] = (q.state != S_IDLE);
               d.rdata[ST_AVAIL_BIT] = q.avail;
               d.rdata[ST_LINE_BIT] = q.line_s2;
               d.rdata[ST_EXT_BIT] = q.ext;
            end
            OFF_RESULT:
            begin
               d.rdata[RES_W-1:0] = q.result;
               rd_result = 1'b1;
            end
            OFF_OFFSET: d.rdata[15:0] = q.offset;
            OFF_GAIN: d.rdata[7:0] = q.gain;
            OFF_INT_STATUS: d.rdata[EVT_W-1:0] = q.ist;
            OFF_INT_ENABLE: d.rdata[EVT_W-1:0] = q.ien;
            // Write-only registers read as zero
            OFF_CTRL, OFF_INT_CLEAR: d.rdata = '0;
            default: d.rresp = RESP_SLVERR;
         endcase
      end
      if (q.rvalid && rready)
      begin
         d.rvalid = 1'b0;
         d.arrdy = 1'b1;
      end
      // Reading the result consumes the data-available flag
      if (rd_result)
      begin
         d.avail = 1'b0;
      end
      // Conversion sequencer
      unique case (q.state)
         S_IDLE:
         begin
            if (cmd_def || cmd_mod)
            begin
               d.state = S_MEAS;
               d.busy = 1'b1;
               d.ext = 1'b0;
               d.mod = cmd_mod & ~cmd_def;
            end
            else if (trig_fall)
            begin
               d.state = S_MEAS;
               d.busy = 1'b0;
               d.ext = 1'b1;
               d.mod = 1'b1;
            end
            d.cnt = '0;
            d.phase = '0;
            d.line = q.line_s2;
            // Default conversions run on the stored values, others on the altered ones
            d.gain_trim = (cmd_def || !(cmd_mod || trig_fall)) ? DEF_GAIN : q.gain;
         end
         S_MEAS:
         begin
            d.cnt = q.cnt + 1'b1;
            if (mem_we)
            begin
               d.cnt = '0;
               d.phase = q.phase + 1'b1;
               if (q.phase == LAST_PHASE)
               begin
                  d.state = S_VERN;
               end
            end
         end
         S_VERN:
         begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == VERN_LEN - 1'b1)
            begin
               d.cnt = '0;
               d.sidx = '0;
               // Vernier seeds the sum; the offset is folded in here
               d.acc = RES_W'(vernier_count)
                  + RES_W'(signed'(q.mod ? q.offset : DEF_OFFSET));
               d.state = S_SUM;
            end
         end
         S_SUM:
         begin
            // Read data lags the index by one cycle
            if (q.sidx != 4'h0)
            begin
               d.acc = q.acc + RES_W'(mem_rdata);
            end
            if (q.sidx == SUM_END)
            begin
               d.state = S_LATCH;
            end
            else
            begin
               d.sidx = q.sidx + 1'b1;
            end
         end
         S_LATCH:
         begin
            d.result = q.acc;
            d.avail = 1'b1;
            evt[EV_DONE_BIT] = 1'b1;
            d.cnt = '0;
            d.state = S_AZ;
         end
         S_AZ:
         begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == AZ_LEN - 1'b1)
            begin
               d.state = S_IDLE;
               d.busy = 1'b0;
               d.ext = 1'b0;
               evt[EV_AZ_BIT] = 1'b1;
            end
         end
      endcase
      // Starts outside idle are dropped and only reported
      if (q.state != S_IDLE && (cmd_def || cmd_mod || trig_fall))
      begin
         evt[EV_REFUSE_BIT] = 1'b1;
      end
      // Set beats a clear arriving in the same cycle
      d.ist = (q.ist & ~clr) | evt;
      d.irq = |(d.ist & d.ien);
      d.busy_n = ~d.busy;
      d.rdy_out = (d.state == S_AZ);
      d.int_en = (d.state == S_MEAS);
      d.vern_en = (d.state == S_VERN);
      d.az_en = (d.state == S_AZ);
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.state <= S_IDLE;
         q.trig_s1 <= PIN_IDLE_RST;
         q.trig_s2 <= PIN_IDLE_RST;
         q.trig_prev <= PIN_IDLE_RST;
         q.line_s1 <= PIN_IDLE_RST;
         q.line_s2 <= PIN_IDLE_RST;
         q.line <= PIN_IDLE_RST;
         q.busy_n <= 1'b1;
         q.awrdy <= 1'b1;
         q.wrdy <= 1'b1;
         q.arrdy <= 1'b1;
         q.gain <= DEF_GAIN;
         q.gain_trim <= DEF_GAIN;
         q.offset <= DEF_OFFSET;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign awready = q.awrdy;
   assign wready = q.wrdy;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arrdy;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = q.rdata;
   assign busy_out_n = q.busy_n;
   assign result_valid_output = q.rdy_out;
   assign irq = q.irq;
   assign integrate_en = q.int_en;
   assign vernier_en = q.vern_en;
   assign autozero_en = q.az_en;
   assign gain_trim = q.gain_trim;

   // Checks on the sequencer
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_sum_done;
      (q.state == S_SUM) ##1 (q.state == S_LATCH);
   endsequence
   sequence s_az_end;
      (q.state == S_AZ) ##1 (q.state == S_IDLE);
   endsequence

   a_period_select: assert property ((q.state == S_MEAS) |-> (q.cnt < meas_len))
      else $error("measurement timer past its cycle length");
   a_ten_cycles: assert property ((q.state == S_MEAS) ##1 (q.state == S_VERN)
      |-> $past(q.phase) == LAST_PHASE)
      else $error("vernier entered before the tenth cycle");
   a_sum_latch: assert property (s_sum_done |=> (q.result == $past(q.acc) && q.avail))
      else $error("summed value not latched with data flag");
   a_autozero_len: assert property (s_az_end |-> $past(q.cnt) == AZ_LEN - 1'b1)
      else $error("auto-zero ended at wrong count");
   a_ext_start: assert property ((trig_fall && q.state == S_IDLE && !q.aw_have)
      |=> (q.state == S_MEAS && q.ext && q.mod))
      else $error("trigger edge did not start a modified conversion");
   a_ext_no_busy: assert property ((q.ext && q.state != S_IDLE)
      |-> (!q.busy && busy_out_n))
      else $error("busy shown for external conversion");
   a_ready_window: assert property (s_az_end |-> ##1 !result_valid_output)
      else $error("result valid not dropped after auto-zero");
   a_busy_inverse: assert property ($rose(q.busy) |=> !busy_out_n ##0 $past(q.state) != S_IDLE)
      else $error("busy pin not inverse of status busy");
   a_mod_gain: assert property (((q.state == S_MEAS) && q.mod && q.cnt == '0 && q.phase == 4'h0)
      |-> (gain_trim == q.gain))
      else $error("modified conversion not using altered gain");
   a_trig_once: assert property ((trig_fall && q.state != S_IDLE) |=> q.ist[EV_REFUSE_BIT])
      else $error("edge during conversion not refused");
endmodule : adc_conv_ctl

// ### adc_ctl_pkg.sv
// Constants, register map and state encoding of the conversion controller
package adc_ctl_pkg;
   // System clock rate
   localparam int unsigned CLK_HZ = 125_000_000;
   // Integration time is 1/30 s (line select high) or 1/25 s (line select low)
   localparam int unsigned INT60_DIV = 30;
   localparam int unsigned INT50_DIV = 25;
   localparam int unsigned INT60_CYC = CLK_HZ / INT60_DIV;
   localparam int unsigned INT50_CYC = CLK_HZ / INT50_DIV;
   // Measurement cycles per conversion
   localparam int unsigned MEAS_CYCLES = 10;
   // Vernier reference integration, milliseconds
   localparam int unsigned VERNIER_MS = 6;
   localparam int unsigned VERN_CYC = (CLK_HZ / 1000) * VERNIER_MS;
   // Integrator reset and auto-zero, milliseconds
   localparam int unsigned AUTOZERO_MS = 10;
   localparam int unsigned AZ_CYC = (CLK_HZ / 1000) * AUTOZERO_MS;
   // Widths
   localparam int unsigned AXI_AW = 8;
   localparam int unsigned CNT_W = 23;
   localparam int unsigned READ_W = 16;
   localparam int unsigned RES_W = 24;
   localparam int unsigned EVT_W = 3;
   // Register byte offsets
   localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_RESULT = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_OFFSET = 8'h0C;
   localparam logic [AXI_AW-1:0] OFF_GAIN = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_INT_STATUS = 8'h14;
   localparam logic [AXI_AW-1:0] OFF_INT_CLEAR = 8'h18;
   localparam logic [AXI_AW-1:0] OFF_INT_ENABLE = 8'h1C;
   // Control register bits (write-one pulses)
   localparam int unsigned CTRL_DEF_BIT = 0;
   localparam int unsigned CTRL_MOD_BIT = 1;
   // Status register bits
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_CONV_BIT = 1;
   localparam int unsigned ST_AVAIL_BIT = 2;
   localparam int unsigned ST_LINE_BIT = 3;
   localparam int unsigned ST_EXT_BIT = 4;
   // Interrupt event bits
   localparam int unsigned EV_DONE_BIT = 0;
   localparam int unsigned EV_AZ_BIT = 1;
   localparam int unsigned EV_REFUSE_BIT = 2;
   // Reset values
   localparam logic [7:0] DEF_GAIN = 8'h80;
   localparam logic [15:0] DEF_OFFSET = 16'h0000;
   localparam logic PIN_IDLE_RST = 1'b1;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states
   typedef enum logic [2:0] {S_IDLE, S_MEAS, S_VERN, S_SUM, S_LATCH, S_AZ} state_e;
endpackage : adc_ctl_pkg

// ### adc_host_model.sv
// Host-side partner: convert trigger with minimum level hold, integrator counts
`timescale 1ns/1ps
module adc_host_model #(
   parameter int HOLD = 188
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Bench requests
   input wire logic trig_req,
   input wire logic [15:0] dval,
   input wire logic [15:0] vval,
   // Toward the converter
   output logic trig,
   output logic [15:0] deint_count,
   output logic [15:0] vernier_count
);
   int cnt; // Cycles left in the current level
   // Counts only change between conversions, so they are passed straight through
   assign deint_count = dval;
   assign vernier_count = vval;
   // Each level stands HOLD cycles at least, so a short request cannot glitch the pin
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         trig <= 1'b1;
         cnt <= 0;
      end
      else if (cnt != 0)
         cnt <= cnt - 1;
      else if (!trig)
      begin
         trig <= 1'b1;
         cnt <= HOLD - 1;
      end
      else if (trig_req)
      begin
         trig <= 1'b0;
         cnt <= HOLD - 1;
      end
   end
endmodule : adc_host_model

// ### reading_mem.sv
// Small store for the individual integrate/de-integrate readings
`timescale 1ns/1ps
module reading_mem #(
   parameter int unsigned W = 16,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read port, data one cycle after address
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   // All storage in one packed state word
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } mem_s;
   mem_s q;
   mem_s d;

   // Write and registered read
   always_comb
   begin
      d = q;
      if (we)
      begin
         d.mem[waddr] = wdata;
      end
      d.rdata = q.mem[raddr];
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
endmodule : reading_mem

// ### test_integrating_adc_conversion_control.sv
// Self-checking bench for the conversion controller
`timescale 1ns/1ps
module test_integrating_adc_conversion_control;
   import adc_ctl_pkg::*;
   // Shortened counts; 1.5 us trigger hold is 188 cycles at 8 ns
   localparam int I60 = 400;
   localparam int I50 = 500;
   localparam int VN = 20;
   localparam int AZ = 30;
   localparam int HOLD = 188;
   // Reset held at least 3 us is 375 cycles at 8 ns
   localparam int RST_HOLD = 375;
   logic clk_sys, sys_rst;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic trig_req, ext_trig, line_sel, busy_out_n, rv_out, irq, int_en, vern_en, az_en;
   logic [15:0] dval, vval, dcnt, vcnt, ofr;
   logic [7:0] gain_trim, gr, gain_e;
   logic busy_n_e; // Busy pin level expected while measuring
   logic [3:0] en; // Phase indications whose lengths are measured
   int num_errors, n_tests, cyc, seed;
   int cnt[4];
   int len_e[4];
   logic [33:0] rq[$]; // Expected read response and data
   logic [1:0] bq[$]; // Expected write response
   assign en = {rv_out, az_en, vern_en, int_en};
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   adc_conv_ctl #(.P_INT60_CYC(I60), .P_INT50_CYC(I50), .P_VERN_CYC(VN), .P_AZ_CYC(AZ)) uut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .external_convert_trigger(ext_trig),
      .line_frequency_select(line_sel), .busy_out_n(busy_out_n), .result_valid_output(rv_out),
      .irq(irq), .deint_count(dcnt), .vernier_count(vcnt), .integrate_en(int_en),
      .vernier_en(vern_en), .autozero_en(az_en), .gain_trim(gain_trim));
   adc_host_model #(.HOLD(HOLD)) host (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .trig_req(trig_req), .dval(dval), .vval(vval), .trig(ext_trig),
      .deint_count(dcnt), .vernier_count(vcnt));
   // Compare one value and count it
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   // Bus write; address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ad, wd;
      ad = 0;
      wd = 0;
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
         begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk_sys); while (!bvalid);
      bready <= 1'b0;
   endtask : axw
   // Bus read; the watcher compares the data against the note
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      rq.push_back({er, d});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk_sys); while (!rvalid);
      rready <= 1'b0;
   endtask : axr
   // Status word from its fields
   function automatic logic [31:0] st(input logic b, c, a, l, x);
      return (32'(b) << ST_BUSY_BIT) | (32'(c) << ST_CONV_BIT) | (32'(a) << ST_AVAIL_BIT)
         | (32'(l) << ST_LINE_BIT) | (32'(x) << ST_EXT_BIT);
   endfunction : st
   // One conversion: kind 0 default command, 1 modified command, 2 external trigger
   task automatic conv(input int kind, input logic line);
      logic [15:0] d, v;
      logic [23:0] e;
      int k;
      d = 16'($random(seed));
      v = 16'($random(seed));
      e = 24'(v) + 24'(d) * 24'd10 + ((kind != 0) ? {{8{ofr[15]}}, ofr} : 24'h000000);
      dval <= d;
      vval <= v;
      line_sel <= line;
      len_e[0] = line ? I60 : I50;
      busy_n_e = (kind == 2);
      gain_e = (kind != 0) ? gr : DEF_GAIN;
      @(posedge clk_sys);
      if (kind < 2)
         axw(OFF_CTRL, (kind == 1) ? 32'h00000002 : 32'h00000001, RESP_OKAY);
      else
         trig_req <= 1'b1;
      for (k = 0; k < 100 && !int_en; k++) @(posedge clk_sys);
      axr(OFF_STATUS, st(kind < 2, 1'b1, 1'b0, line, kind == 2), RESP_OKAY);
      if (kind == 2)
         axw(OFF_CTRL, 32'h00000001, RESP_OKAY);
      for (k = 0; k < 2000 && !rv_out; k++) @(posedge clk_sys);
      for (k = 0; k < 200 && rv_out; k++) @(posedge clk_sys);
      trig_req <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("busy_idle", 32'(busy_out_n), 32'h00000001);
      axr(OFF_RESULT, 32'(e), RESP_OKAY);
      if (kind < 2)
         axr(OFF_STATUS, st(1'b0, 1'b0, 1'b0, line, 1'b0), RESP_OKAY);
      $display("test conversion kind %0d done", kind);
   endtask : conv
   // Watcher: phase lengths, pins at the end of measurement, bus answers, timeout
   always @(posedge clk_sys)
   begin
      logic [33:0] n;
      if (!sys_rst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (en[i])
               cnt[i]++;
            else if (cnt[i] != 0)
            begin
               check("phase_len", 32'(cnt[i]), 32'(len_e[i]));
               if (i == 0)
               begin
                  check("busy_n", 32'(busy_out_n), 32'(busy_n_e));
                  check("gain_trim", 32'(gain_trim), 32'(gain_e));
               end
               cnt[i] = 0;
            end
         end
      end
      if (rvalid && rready)
      begin
         n = rq.pop_front();
         check("rdata", rdata, n[31:0]);
         check("rresp", 32'(rresp), 32'(n[33:32]));
      end
      if (bvalid && bready)
         check("bresp", 32'(bresp), 32'(bq.pop_front()));
      cyc++;
      if (cyc == 45000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready, trig_req} = '0;
      wstrb = 4'hF;
      line_sel = 1'b1;
      dval = 16'h0000;
      vval = 16'h0000;
      seed = 51;
      len_e[1] = VN;
      len_e[2] = AZ;
      len_e[3] = AZ;
      sys_rst = 1'b1;
      // No bus access until the reset has been released
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      check("busy_rst", 32'(busy_out_n), 32'h00000001);
      check("rv_rst", 32'(rv_out), 32'h00000000);
      axr(OFF_GAIN, 32'(DEF_GAIN), RESP_OKAY);
      axr(OFF_OFFSET, 32'(DEF_OFFSET), RESP_OKAY);
      axr(OFF_INT_ENABLE, 32'h00000000, RESP_OKAY);
      axr(OFF_STATUS, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0), RESP_OKAY);
      axr(8'h20, 32'h00000000, RESP_SLVERR);
      axw(8'h20, 32'h00000001, RESP_SLVERR);
      gr = 8'($random(seed));
      ofr = 16'($random(seed));
      axw(OFF_GAIN, 32'(gr), RESP_OKAY);
      axw(OFF_OFFSET, 32'(ofr), RESP_OKAY);
      axw(OFF_INT_ENABLE, 32'h00000003, RESP_OKAY);
      $display("test reset and registers done");
      conv(0, 1'b1);
      check("irq_on", 32'(irq), 32'h00000001);
      axr(OFF_INT_STATUS, 32'h00000003, RESP_OKAY);
      axw(OFF_INT_CLEAR, 32'h00000003, RESP_OKAY);
      axw(OFF_INT_ENABLE, 32'h00000000, RESP_OKAY);
      check("irq_clear", 32'(irq), 32'h00000000);
      conv(1, 1'b0);
      check("irq_mask", 32'(irq), 32'h00000000);
      axr(OFF_INT_STATUS, 32'h00000003, RESP_OKAY);
      axw(OFF_INT_CLEAR, 32'h00000003, RESP_OKAY);
      axw(OFF_INT_ENABLE, 32'h00000004, RESP_OKAY);
      conv(2, 1'b1);
      check("irq_refuse", 32'(irq), 32'h00000001);
      axr(OFF_INT_STATUS, 32'h00000007, RESP_OKAY);
      axw(OFF_INT_CLEAR, 32'h00000007, RESP_OKAY);
      axr(OFF_INT_STATUS, 32'h00000000, RESP_OKAY);
      // Second reset in mid-run; supplies are ideal from time zero, so the
      // release is held back until they have been steady for 300 us
      sys_rst <= 1'b1;
      repeat (RST_HOLD) @(posedge clk_sys);
      while ($time < 300_000) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      check("busy_rst2", 32'(busy_out_n), 32'h00000001);
      check("rv_rst2", 32'(rv_out), 32'h00000000);
      check("irq_rst2", 32'(irq), 32'h00000000);
      axr(OFF_GAIN, 32'(DEF_GAIN), RESP_OKAY);
      axr(OFF_OFFSET, 32'(DEF_OFFSET), RESP_OKAY);
      axr(OFF_INT_ENABLE, 32'h00000000, RESP_OKAY);
      axr(OFF_STATUS, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0), RESP_OKAY);
      $display("test mid-run reset done");
      results();
   end
endmodule : test_integrating_adc_conversion_control
